// ---- mic_core_model.sv ----
// mic_core_model: stand-in for the core side of the vector handshake.
// assumes the bench says when the core may take and when it returns.
`timescale 1ns/1ps
module mic_core_model (
  input  wire logic        core_clk,   // core clock
  input  wire logic        rst_n,      // sync reset, low
  input  wire logic        int_req,    // request from controller
  input  wire logic [15:0] int_vector, // offered vector
  input  wire logic        ack_en,     // bench lets the core take
  input  wire logic        ret_go,     // bench asks for a return
  output logic             int_ack,    // take pulse
  output logic             int_return, // return pulse
  output logic      [15:0] taken_vec,  // last vector taken
  output logic      [7:0]  taken_cnt   // vectors taken so far
);
  //////////////////////////////////////////////////////////////////////
  // ack held to the edge that takes it; vector kept at that same edge,
  // since the offer may still change to a better winner before then
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      int_ack    <= 1'b0;
      int_return <= 1'b0;
      taken_vec  <= 16'h0000;
      taken_cnt  <= 8'h00;
    end else begin
      int_return <= ret_go;
      if (int_ack) begin
        int_ack <= 1'b0;
        if (int_req) begin
          taken_vec <= int_vector;
          taken_cnt <= taken_cnt + 8'h01;
        end
      end else if (int_req && ack_en) begin
        int_ack <= 1'b1;
      end
    end
  end
endmodule // mic_core_model

// ---- mic_intc.sv ----
// mic_intc: interrupt controller beside the 8051-style core.
// assumes one clock, a synchronous low reset, level inputs from
// peripherals sampled on CORE_CLK and one-cycle ack/return pulses.
//
// What this block does
// R1 - accepted enabled request hands the core its fixed vector address
// R2 - running routine is only preempted by a strictly higher level
// R3 - vectors 0003, 000b, 0013, 001b; serial 0023; timer two 002b
// R4 - vectors radio ready 0043, radio 004b, shared spi/two-wire 0053
// R5 - vectors wakeup pin 005b, miscellaneous 0063, tick 006b
// R6 - pin and power-fail low; timers, serial, radio ready high; others edge-sensed
// R7 - miscellaneous is the or of oscillator, converter and random
// R8 - pending oscillator-started request masks converter and random
// R9 - radio, wakeup pin, misc and tick need their wakeup enable
// R10 - enable-first bit 7 globally blocks every interrupt when low
// R11 - enable-first bits 0-5 enable pin, t0, power, t1, serial, t2
// R12 - enable-second bits 0-5 and 7 enable the remaining sources
// R13 - extension bits 2,1,0 gate two-wire, master, slave spi done
// R14 - extension bits 5:3 gate pins 2:0 onto pin request; reset 01
// R15 - six groups take level from high and low priority bit x
// R16 - group membership pairs low and high vector sources
// R17 - level is high bit then low bit; 11 highest
// R18 - edge flags auto-clear on entry; timer two, radio ready do not
// R19 - equal levels are served in ascending vector order
// R20 - nested levels tracked and released on return-from-interrupt
// R21 - shared-vector sources keep own flags; request while any pends
`timescale 1ns/1ps
module mic_intc
  import mic_pkg::*;
(
  input  wire logic        CORE_CLK,         // core clock, 100 MHz
  input  wire logic        RSTN,             // sync reset, active low
  input  wire logic [7:0]  SFR_ADDR,         // register address
  input  wire logic        SFR_WR,           // write strobe
  input  wire logic [7:0]  SFR_WDATA,        // write data
  output logic      [7:0]  SFR_RDATA,        // read data, one cycle on
  input  wire logic [2:0]  PIN_N,            // external pins, low active
  input  wire logic        POWER_FAIL_N,     // power-fail, low active
  input  wire logic        TIMER_ZERO_OVERFLOW,       // level
  input  wire logic        TIMER_ONE_OVERFLOW,        // level
  input  wire logic        SERIAL_RECEIVE_REQUEST,    // level
  input  wire logic        SERIAL_TRANSMIT_REQUEST,   // level
  input  wire logic        TIMER_TWO_OVERFLOW,        // level
  input  wire logic        TIMER_TWO_EXTERNAL_RELOAD, // level
  input  wire logic        RADIO_SPI_READY,           // level
  input  wire logic        RADIO_REQUEST,             // either edge
  input  wire logic        MASTER_SPI_DONE,           // either edge
  input  wire logic        TWO_WIRE_DONE,             // either edge
  input  wire logic        SLAVE_SPI_DONE,            // either edge
  input  wire logic        WAKEUP_ON_PIN_REQUEST,     // rising edge
  input  wire logic        OSCILLATOR_STARTED_REQUEST, // rising edge
  input  wire logic        CONVERTER_READY_REQUEST,   // rising edge
  input  wire logic        RANDOM_READY_REQUEST,      // rising edge
  input  wire logic        WAKEUP_TICK,               // rising edge
  input  wire logic [3:0]  WAKEUP_ENABLE,    // wakeup config enables
  input  wire logic        OSC_IRQ_ENABLE,   // clock control bit 3
  input  wire logic        INT_ACK,          // core took the vector
  input  wire logic        INT_RETURN,       // core ran return
  output logic             INT_REQ,          // request to the core
  output logic      [15:0] INT_VECTOR,       // vector address
  output logic      [3:0]  ACTIVE_LEVELS     // levels in service
);

  ////////////////////////////////////////////////////////////////////////
  // registers

  logic [7:0]       ext_reg, ext_next;
  logic [7:0]       en0_reg, en0_next;
  logic [7:0]       en1_reg, en1_next;
  logic [7:0]       plo_reg, plo_next;
  logic [7:0]       phi_reg, phi_next;
  logic [7:0]       rdata_reg, rdata_next;
  logic [NFLAG-1:0] flag_reg, flag_next;
  logic [NFLAG-1:0] prev_reg, prev_next;
  logic [3:0]       svc_reg, svc_next;
  logic             req_reg, req_next;
  logic [3:0]       idx_reg, idx_next;
  logic [1:0]       lvl_reg, lvl_next;
  logic [15:0]      vec_reg, vec_next;

  logic [NFLAG-1:0] edge_in, edge_hit, flag_gate, flag_set, flag_clr;
  logic [NSRC-1:0]  req;
  logic [2*NSRC-1:0] lvl;
  logic             take;
  logic [1:0]       floor_lv;
  logic             pick_valid;
  logic [3:0]       pick_idx;
  logic [1:0]       pick_lvl;

  ////////////////////////////////////////////////////////////////////////
  // register writes and reads; unused bits read zero

  always_comb begin
    ext_next   = ext_reg;
    en0_next   = en0_reg;
    en1_next   = en1_reg;
    plo_next   = plo_reg;
    phi_next   = phi_reg;
    rdata_next = 8'h00;
    if (SFR_WR) begin
      if (SFR_ADDR == ADDR_EXT) begin
        ext_next = SFR_WDATA & MASK_LOW6; // R13 R14
      end else if (SFR_ADDR == ADDR_EN0) begin
        en0_next = SFR_WDATA & MASK_EN; // R10 R11
      end else if (SFR_ADDR == ADDR_EN1) begin
        en1_next = SFR_WDATA & MASK_EN; // R12
      end else if (SFR_ADDR == ADDR_PLO) begin
        plo_next = SFR_WDATA & MASK_LOW6; // R15
      end else if (SFR_ADDR == ADDR_PHI) begin
        phi_next = SFR_WDATA & MASK_LOW6; // R15
      end
    end
    if (SFR_ADDR == ADDR_EXT) begin
      rdata_next = ext_reg;
    end else if (SFR_ADDR == ADDR_EN0) begin
      rdata_next = en0_reg;
    end else if (SFR_ADDR == ADDR_EN1) begin
      rdata_next = en1_reg;
    end else if (SFR_ADDR == ADDR_PLO) begin
      rdata_next = plo_reg;
    end else if (SFR_ADDR == ADDR_PHI) begin
      rdata_next = phi_reg;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RSTN) begin
      ext_reg   <= RST_EXT; // R14
      en0_reg   <= RST_ZERO;
      en1_reg   <= RST_ZERO;
      plo_reg   <= RST_ZERO;
      phi_reg   <= RST_ZERO;
      rdata_reg <= RST_ZERO;
    end else begin
      ext_reg   <= ext_next;
      en0_reg   <= en0_next;
      en1_reg   <= en1_next;
      plo_reg   <= plo_next;
      phi_reg   <= phi_next;
      rdata_reg <= rdata_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // edge-sensed sources latch into flags of their own

  assign edge_in = {WAKEUP_TICK, RANDOM_READY_REQUEST,
                    CONVERTER_READY_REQUEST, OSCILLATOR_STARTED_REQUEST,
                    WAKEUP_ON_PIN_REQUEST, SLAVE_SPI_DONE, TWO_WIRE_DONE,
                    MASTER_SPI_DONE, RADIO_REQUEST};

  // a flag cannot set while its wakeup source is off; the oscillator
  // flag, once pending, hides converter and random events
  assign flag_gate = {WAKEUP_ENABLE[WU_TICK],
                      {2{WAKEUP_ENABLE[WU_MISC] & ~flag_reg[E_OSC]}}, // R8
                      WAKEUP_ENABLE[WU_MISC] & OSC_IRQ_ENABLE,
                      WAKEUP_ENABLE[WU_PIN], 3'b111,
                      WAKEUP_ENABLE[WU_RADIO]}; // R9

  assign take = INT_ACK & req_reg;

  genvar f;
  generate
    for (f = 0; f < NFLAG; f++) begin : g_flag
      assign edge_hit[f] = BOTH_EDGES[f] ? (edge_in[f] ^ prev_reg[f])
                                         : (edge_in[f] & ~prev_reg[f]); // R6
      assign flag_set[f] = edge_hit[f] & flag_gate[f];
      assign flag_clr[f] = take & (idx_reg == OWNER[f]); // R18
      // an event in the clearing cycle survives
      assign flag_next[f] = flag_set[f] | (flag_reg[f] & ~flag_clr[f]);
      assign prev_next[f] = edge_in[f];
    end
  endgenerate

  always_ff @(posedge CORE_CLK) begin
    if (!RSTN) begin
      flag_reg <= '0;
      prev_reg <= '0;
    end else begin
      flag_reg <= flag_next;
      prev_reg <= prev_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // per-vector requests after individual enables

  always_comb begin
    req         = '0;
    req[S_PIN]  = en0_reg[EN0_PIN]
                & |(~PIN_N & ext_reg[EXT_PIN_HI:EXT_PIN_LO]); // R6 R14
    req[S_T0]   = en0_reg[EN0_T0] & TIMER_ZERO_OVERFLOW; // R11
    req[S_POF]  = en0_reg[EN0_POF] & ~POWER_FAIL_N; // R6
    req[S_T1]   = en0_reg[EN0_T1] & TIMER_ONE_OVERFLOW;
    req[S_SER]  = en0_reg[EN0_SER]
                & (SERIAL_RECEIVE_REQUEST | SERIAL_TRANSMIT_REQUEST); // R21
    req[S_T2]   = en0_reg[EN0_T2] & (TIMER_TWO_OVERFLOW
                | (en1_reg[EN1_TIMER_TWO_EXTERNAL_RELOAD] & TIMER_TWO_EXTERNAL_RELOAD)); // R12
    req[S_RDY]  = en1_reg[EN1_RADIO_SPI_READY] & RADIO_SPI_READY;
    req[S_RAD]  = en1_reg[EN1_RADIO] & flag_reg[E_RAD];
    req[S_SPI]  = en1_reg[EN1_SPI]
                & ((flag_reg[E_WIRE] & ext_reg[EXT_WIRE])
                |  (flag_reg[E_MSPI] & ext_reg[EXT_MSPI])
                |  (flag_reg[E_SSPI] & ext_reg[EXT_SSPI])); // R13 R21
    req[S_WUOP] = en1_reg[EN1_WUOP] & flag_reg[E_WUOP];
    req[S_MISC] = en1_reg[EN1_MISC] & (flag_reg[E_OSC]
                | flag_reg[E_CONV] | flag_reg[E_RNG]); // R7
    req[S_TICK] = en1_reg[EN1_TICK] & flag_reg[E_TICK];
    if (!en0_reg[EN0_GLOBAL]) begin
      req = '0; // R10
    end
  end

  // level of each source from its group's high and low bits
  genvar s;
  generate
    for (s = 0; s < NSRC; s++) begin : g_lvl
      assign lvl[2*s+:2] = {phi_reg[GROUP[s]], plo_reg[GROUP[s]]}; // R15 R16 R17
    end
  endgenerate

  // highest level still in service is the preemption floor
  assign floor_lv = svc_reg[3] ? 2'd3 : svc_reg[2] ? 2'd2 :
                    svc_reg[1] ? 2'd1 : 2'd0;

  mic_pick u_pick (
    .req      (req),
    .lvl      (lvl),
    .busy     (|svc_reg),
    .floor_lv (floor_lv),
    .valid    (pick_valid),
    .idx      (pick_idx),
    .level    (pick_lvl)
  );

  ////////////////////////////////////////////////////////////////////////
  // core handshake and in-service level tracking

  always_comb begin
    svc_next = svc_reg;
    if (INT_RETURN) begin
      // release only the innermost routine's level
      if (svc_reg[3]) begin
        svc_next[3] = 1'b0; // R20
      end else if (svc_reg[2]) begin
        svc_next[2] = 1'b0;
      end else if (svc_reg[1]) begin
        svc_next[1] = 1'b0;
      end else begin
        svc_next[0] = 1'b0;
      end
    end
    if (take) begin
      svc_next[lvl_reg] = 1'b1; // R2 R20
    end
    // one idle cycle after a take lets flags and floor settle
    req_next = pick_valid & ~take; // R1
    idx_next = pick_idx;
    lvl_next = pick_lvl;
    vec_next = VECTOR[pick_idx]; // R3 R4 R5
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RSTN) begin
      svc_reg <= 4'h0;
      req_reg <= 1'b0;
      idx_reg <= 4'h0;
      lvl_reg <= 2'h0;
      vec_reg <= 16'h0000;
    end else begin
      svc_reg <= svc_next;
      req_reg <= req_next;
      idx_reg <= idx_next;
      lvl_reg <= lvl_next;
      vec_reg <= vec_next;
    end
  end

  assign SFR_RDATA     = rdata_reg;
  assign INT_REQ       = req_reg;
  assign INT_VECTOR    = vec_reg;
  assign ACTIVE_LEVELS = svc_reg;

  ////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RSTN);

  sequence take_s;
    INT_ACK && req_reg;
  endsequence

  sequence tick_take_s;
    take_s ##0 (idx_reg == 4'd11);
  endsequence

  pin_vector_a: assert property ( // R3
    req_reg && idx_reg == 4'd0 |-> INT_VECTOR == 16'h0003)
    else $error("pin vector wrong");

  spi_vector_a: assert property ( // R4
    req_reg && idx_reg == 4'd8 |-> INT_VECTOR == 16'h0053)
    else $error("shared spi vector wrong");

  tick_vector_a: assert property ( // R5
    req_reg && idx_reg == 4'd11 |-> INT_VECTOR == 16'h006b)
    else $error("tick vector wrong");

  global_off_a: assert property ( // R10
    !en0_reg[7] ##1 !en0_reg[7] |=> !INT_REQ)
    else $error("request while globally disabled");

  preempt_level_a: assert property ( // R2
    req_reg && svc_reg != 4'h0 |-> lvl_reg > floor_lv)
    else $error("preemption without higher level");

  take_marks_a: assert property ( // R1
    take_s |=> !INT_REQ && ACTIVE_LEVELS != 4'h0)
    else $error("take not recorded");

  tick_clear_a: assert property ( // R18
    tick_take_s |=> !flag_reg[8] || $past(flag_set[8]))
    else $error("tick flag not auto-cleared");

  return_free_a: assert property ( // R20
    INT_RETURN && !take && svc_reg == 4'h1 |=> svc_reg == 4'h0)
    else $error("return did not release level");

  osc_mask_a: assert property ( // R8
    flag_reg[5] && !flag_reg[6] |=> !flag_reg[6])
    else $error("converter flag set under oscillator");

  misc_wake_a: assert property ( // R9
    !WAKEUP_ENABLE[2] && !flag_reg[7] |=> !flag_reg[7])
    else $error("random flag set without wakeup");

endmodule // mic_intc

// ---- mic_intc_tb_top.sv ----
// mic_intc_tb_top: self-checking bench for the interrupt controller.
// assumes the core model above; peripheral lines are driven here.
`timescale 1ns/1ps
module mic_intc_tb_top
  import mic_pkg::*;
;
  logic        core_clk, rst_n, sfr_wr, ack_en, ret_go, osc_en;
  logic        int_ack, int_return, int_req;
  logic [7:0]  sfr_addr, sfr_wdata, sfr_rdata, taken_cnt;
  logic [8:0]  lv, ed;
  logic [3:0]  wk_en, act;
  logic [1:0]  pin_hi_n;
  logic [15:0] int_vector, taken_vec;
  int          err_total, checked;
  localparam logic [7:0] RA [5] = '{8'ha6, 8'ha8, 8'ha9, 8'hb8, 8'hb9};
  localparam logic [7:0] RR [5] = '{8'h01, 8'h00, 8'h00, 8'h00, 8'h00};
  localparam logic [7:0] RM [5] = '{8'h3f, 8'hbf, 8'h3f, 8'hbf, 8'h3f};
  localparam logic [15:0] LV [9] = '{16'h0003, 16'h000b, 16'h0013,
    16'h001b, 16'h0023, 16'h0023, 16'h002b, 16'h002b, 16'h0043};
  localparam logic [15:0] EV [9] = '{16'h004b, 16'h0053, 16'h0053,
    16'h0053, 16'h005b, 16'h0063, 16'h0063, 16'h0063, 16'h006b};

  //////////////////////////////////////////////////////////////////////
  // pins 2:1 driven low active on their own; pin 0 follows lv[0]
  mic_intc DUT (.CORE_CLK(core_clk), .RSTN(rst_n), .SFR_ADDR(sfr_addr),
    .SFR_WR(sfr_wr), .SFR_WDATA(sfr_wdata), .SFR_RDATA(sfr_rdata),
    .PIN_N({pin_hi_n, ~lv[0]}), .POWER_FAIL_N(~lv[2]),
    .TIMER_ZERO_OVERFLOW(lv[1]), .TIMER_ONE_OVERFLOW(lv[3]),
    .SERIAL_RECEIVE_REQUEST(lv[4]), .SERIAL_TRANSMIT_REQUEST(lv[5]),
    .TIMER_TWO_OVERFLOW(lv[6]), .TIMER_TWO_EXTERNAL_RELOAD(lv[7]),
    .RADIO_SPI_READY(lv[8]), .RADIO_REQUEST(ed[0]),
    .MASTER_SPI_DONE(ed[1]), .TWO_WIRE_DONE(ed[2]),
    .SLAVE_SPI_DONE(ed[3]), .WAKEUP_ON_PIN_REQUEST(ed[4]),
    .OSCILLATOR_STARTED_REQUEST(ed[5]), .CONVERTER_READY_REQUEST(ed[6]),
    .RANDOM_READY_REQUEST(ed[7]), .WAKEUP_TICK(ed[8]),
    .WAKEUP_ENABLE(wk_en), .OSC_IRQ_ENABLE(osc_en), .INT_ACK(int_ack),
    .INT_RETURN(int_return), .INT_REQ(int_req),
    .INT_VECTOR(int_vector), .ACTIVE_LEVELS(act));

  mic_core_model core (.core_clk(core_clk), .rst_n(rst_n),
    .int_req(int_req), .int_vector(int_vector), .ack_en(ack_en),
    .ret_go(ret_go), .int_ack(int_ack), .int_return(int_return),
    .taken_vec(taken_vec), .taken_cnt(taken_cnt));

  //////////////////////////////////////////////////////////////////////
  // shared helpers; inputs move 1 ns after the rising edge
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  task automatic bad(input string m);
    $display("BAD %0t %s", $time, m);
    err_total++;
  endtask

  task automatic step(input int n);
    repeat (n) begin
      @(posedge core_clk);
      #1;
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    sfr_addr  = a;
    sfr_wdata = d;
    sfr_wr    = 1'b1;
    step(1);
    sfr_wr    = 1'b0;
    step(1); // gap so a following write never re-raises in this step
  endtask

  // read data lands one edge after the address edge
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    sfr_addr = a;
    step(2);
    checked++;
    if (sfr_rdata !== e) bad("read data");
  endtask

  // bounded wait for the core model to take a vector
  task automatic take(input logic [15:0] e);
    logic [7:0] c0;
    int         n;
    c0 = taken_cnt;
    n  = 0;
    while (taken_cnt === c0 && n < 40) begin
      step(1);
      n++;
    end
    checked++;
    if (taken_cnt === c0) bad("no vector taken");
    else if (taken_vec !== e) bad("wrong vector");
  endtask

  task automatic ret();
    ret_go = 1'b1;
    step(1);
    ret_go = 1'b0;
    step(3);
  endtask

  task automatic quiet(input int n);
    repeat (n) begin
      step(1);
      checked++;
      if (int_req !== 1'b0) bad("unexpected request");
    end
  endtask

  task automatic actchk(input logic [3:0] e);
    checked++;
    if (act !== e) bad("in-service levels");
  endtask

  //////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_regs();
    for (int i = 0; i < 5; i++) rd(RA[i], RR[i]);
    rd(8'ha7, 8'h00);
    for (int i = 0; i < 5; i++) wr(RA[i], 8'hff);
    wr(8'ha7, 8'hff);
    for (int i = 0; i < 5; i++) rd(RA[i], RM[i]);
    rd(8'ha7, 8'h00);
    wr(ADDR_PLO, 8'h00);
    wr(ADDR_PHI, 8'h00);
  endtask

  // level sources stay pending after entry: taken again after return
  task automatic t_levels();
    for (int i = 0; i < 9; i++) begin
      lv[i] = 1'b1;
      take(LV[i]);
      if (i == 0) actchk(4'h1);
      ret();
      take(LV[i]);
      lv[i] = 1'b0;
      ret();
    end
  endtask

  task automatic t_edges();
    for (int e = 0; e < 9; e++) begin
      ed[e] = 1'b1;
      take(EV[e]);
      ret();
      quiet(4);
      ed[e] = 1'b0;
      if (e < 4) begin
        take(EV[e]);
        ret();
      end else begin
        quiet(4);
      end
    end
  endtask

  task automatic t_gates();
    wr(ADDR_EN0, 8'h7f);
    lv[1] = 1'b1;
    quiet(5);
    wr(ADDR_EN0, 8'hff);
    take(16'h000b);
    lv[1] = 1'b0;
    ret();
    wr(ADDR_EXT, 8'h37);
    lv[0] = 1'b1;
    quiet(5);
    lv[0] = 1'b0;
    wr(ADDR_EXT, 8'h27);
    pin_hi_n = 2'b10;
    quiet(5);
    pin_hi_n = 2'b00;
    take(16'h0003);
    pin_hi_n = 2'b11;
    ret();
    wr(ADDR_EXT, 8'h3b);
    ed[2] = 1'b1;
    quiet(5);
    ed[1] = 1'b1;
    take(16'h0053);
    ret();
    wr(ADDR_EXT, 8'h3f);
    wr(ADDR_EN1, 8'h3f);
    lv[7] = 1'b1;
    quiet(5);
    wr(ADDR_EN1, 8'hbf);
    take(16'h002b);
    lv[7] = 1'b0;
    ret();
    wk_en = 4'h7;
    ed[8] = 1'b1;
    quiet(5);
    wk_en = 4'hf;
    // pending oscillator flag keeps the converter flag from setting
    ack_en = 1'b0;
    ed[5]  = 1'b1;
    step(3);
    ed[6]  = 1'b1;
    step(3);
    ack_en = 1'b1;
    take(16'h0063);
    ret();
    quiet(4);
    ed[5]  = 1'b0;
    ed[6]  = 1'b0;
    osc_en = 1'b0;
    step(1);
    ed[5]  = 1'b1;
    quiet(5);
    ed[6]  = 1'b1;
    take(16'h0063);
    ret();
  endtask

  task automatic t_prio();
    ack_en = 1'b0;
    wr(ADDR_PHI, 8'h02);
    lv[0]  = 1'b1;
    lv[1]  = 1'b1;
    step(4);
    ack_en = 1'b1;
    take(16'h000b);
    actchk(4'h4);
    quiet(4);
    lv[1] = 1'b0;
    ret();
    take(16'h0003);
    lv[0] = 1'b0;
    ret();
    // equal levels: lower vector first, then no equal-level preemption
    wr(ADDR_PHI, 8'h00);
    wr(ADDR_PLO, 8'h0a);
    ack_en = 1'b0;
    lv[3]  = 1'b1;
    lv[1]  = 1'b1;
    step(4);
    ack_en = 1'b1;
    take(16'h000b);
    lv[1] = 1'b0;
    ret();
    take(16'h001b);
    lv[1] = 1'b1;
    quiet(4);
    wr(ADDR_PHI, 8'h01);
    lv[0] = 1'b1;
    take(16'h0003);
    actchk(4'h6);
    lv[0] = 1'b0;
    ret();
    actchk(4'h2);
    quiet(3);
    lv[3] = 1'b0;
    ret();
    take(16'h000b);
    lv[1] = 1'b0;
    ret();
  endtask

  //////////////////////////////////////////////////////////////////////
  // verdict, main sequence and hang guard
  task automatic results();
    $display("checks %0d errors %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  initial begin
    err_total = 0;
    checked   = 0;
    rst_n     = 1'b0;
    sfr_wr    = 1'b0;
    sfr_addr  = 8'h00;
    sfr_wdata = 8'h00;
    ack_en    = 1'b1;
    ret_go    = 1'b0;
    osc_en    = 1'b1;
    wk_en     = 4'hf;
    pin_hi_n  = 2'b11;
    lv        = 9'h000;
    ed        = 9'h000;
    step(6);
    rst_n = 1'b1;
    t_regs();
    wr(ADDR_EN0, 8'hff);
    wr(ADDR_EN1, 8'hbf);
    t_levels();
    t_edges();
    t_gates();
    t_prio();
    results();
  end

  // a stuck run is cut short at 900000 ns, far above the length of a normal run
  initial begin
    #900000;
    bad("run timeout");
    results();
  end
endmodule // mic_intc_tb_top

// ---- mic_pick.sv ----
// mic_pick: combinational winner selection among pending sources.
// assumes requests are already enable-gated by the caller.
`timescale 1ns/1ps
module mic_pick
  import mic_pkg::*;
(
  input  wire logic [NSRC-1:0]   req,      // gated requests
  input  wire logic [2*NSRC-1:0] lvl,      // two-bit level per source
  input  wire logic              busy,     // a routine is in service
  input  wire logic [1:0]        floor_lv, // level of that routine
  output logic                   valid,    // a winner exists
  output logic [3:0]             idx,      // winning source
  output logic [1:0]             level     // winner's level
);

  logic [NSRC-1:0] elig;

  // only strictly higher levels may preempt a running routine
  genvar g;
  generate
    for (g = 0; g < NSRC; g++) begin : g_elig
      assign elig[g] = req[g] & (~busy | (lvl[2*g+:2] > floor_lv)); // R2
    end
  endgenerate

  // walk downward so the lowest vector wins any tie in level
  always_comb begin
    valid = 1'b0;
    idx   = 4'h0;
    level = 2'h0;
    for (int i = NSRC - 1; i >= 0; i--) begin
      if (elig[i] && (!valid || lvl[2*i+:2] >= level)) begin // R19
        valid = 1'b1;
        idx   = 4'(i);
        level = lvl[2*i+:2];
      end
    end
  end

endmodule // mic_pick

// ---- mic_pkg.sv ----
// mic_pkg: constants shared by the interrupt controller and its picker.
// assumes an 8-bit special-function register space and a 100 MHz core.
package mic_pkg;

  ////////////////////////////////////////////////////////////////////////
  // register addresses, write masks and reset values
  localparam logic [7:0] ADDR_EXT  = 8'ha6; // interrupt_extension_enable
  localparam logic [7:0] ADDR_EN0  = 8'ha8; // interrupt_enable_first
  localparam logic [7:0] ADDR_PLO  = 8'ha9; // priority_low_bits
  localparam logic [7:0] ADDR_EN1  = 8'hb8; // interrupt_enable_second
  localparam logic [7:0] ADDR_PHI  = 8'hb9; // priority_high_bits

  localparam logic [7:0] MASK_EN   = 8'hbf; // bit 6 unused
  localparam logic [7:0] MASK_LOW6 = 8'h3f; // bits 7:6 unused
  localparam logic [7:0] RST_EXT   = 8'h01;
  localparam logic [7:0] RST_ZERO  = 8'h00;

  ////////////////////////////////////////////////////////////////////////
  // field positions
  localparam int EN0_PIN    = 0;
  localparam int EN0_T0     = 1;
  localparam int EN0_POF    = 2;
  localparam int EN0_T1     = 3;
  localparam int EN0_SER    = 4;
  localparam int EN0_T2     = 5;
  localparam int EN0_GLOBAL = 7;
  localparam int EN1_RADIO_SPI_READY  = 0;
  localparam int EN1_RADIO  = 1;
  localparam int EN1_SPI    = 2;
  localparam int EN1_WUOP   = 3;
  localparam int EN1_MISC   = 4;
  localparam int EN1_TICK   = 5;
  localparam int EN1_TIMER_TWO_EXTERNAL_RELOAD   = 7;
  localparam int EXT_SSPI   = 0;
  localparam int EXT_MSPI   = 1;
  localparam int EXT_WIRE   = 2;
  localparam int EXT_PIN_LO = 3;
  localparam int EXT_PIN_HI = 5;
  localparam int WU_RADIO   = 0; // wakeup configuration enables
  localparam int WU_PIN     = 1;
  localparam int WU_MISC    = 2;
  localparam int WU_TICK    = 3;

  ////////////////////////////////////////////////////////////////////////
  // vector sources, in ascending vector order
  localparam int NSRC   = 12;
  localparam int S_PIN  = 0;
  localparam int S_T0   = 1;
  localparam int S_POF  = 2;
  localparam int S_T1   = 3;
  localparam int S_SER  = 4;
  localparam int S_T2   = 5;
  localparam int S_RDY  = 6;
  localparam int S_RAD  = 7;
  localparam int S_SPI  = 8;
  localparam int S_WUOP = 9;
  localparam int S_MISC = 10;
  localparam int S_TICK = 11;

  typedef logic [15:0] mic_vec_t;
  localparam mic_vec_t VECTOR [NSRC] = '{
    16'h0003, 16'h000b, 16'h0013, 16'h001b, 16'h0023, 16'h002b,
    16'h0043, 16'h004b, 16'h0053, 16'h005b, 16'h0063, 16'h006b};
  localparam logic [2:0] GROUP [NSRC] = '{
    3'd0, 3'd1, 3'd2, 3'd3, 3'd4, 3'd5,
    3'd1, 3'd0, 3'd2, 3'd3, 3'd4, 3'd5};

  ////////////////////////////////////////////////////////////////////////
  // edge-latched request flags and the vector each one feeds
  localparam int NFLAG  = 9;
  localparam int E_RAD  = 0;
  localparam int E_MSPI = 1;
  localparam int E_WIRE = 2;
  localparam int E_SSPI = 3;
  localparam int E_WUOP = 4;
  localparam int E_OSC  = 5;
  localparam int E_CONV = 6;
  localparam int E_RNG  = 7;
  localparam int E_TICK = 8;
  localparam logic [NFLAG-1:0] BOTH_EDGES = 9'h00f; // else rising only
  localparam logic [3:0] OWNER [NFLAG] = '{
    4'd7, 4'd8, 4'd8, 4'd8, 4'd9, 4'd10, 4'd10, 4'd10, 4'd11};

endpackage
